// ==== hw/uart_baud_frame.v ====
// Behaviour
// - Divisor writes while enabled give unpredictable generator behaviour.
// - Mode 0 at clock/16; mode 2 at clock/32, or /16 when doubled.
// - Modes 1,3 with source 0: clock/((256-reload)*64), or *32 when doubled.
// - Modes 1,3 with source 1: clock/(divisor+16), doubling ignored.
// - Generator control: enable bit 0, source bit 1, both clear on reset.
// - A stop bit sampled low flags a framing error.
// - Framing errors always show in the status register.
// - With view bit set, control bit 7 is the framing flag, else mode bit.
// - Eleven consecutive low bits detect a break in modes 2,3, twenty in mode 1; reported in status.
// - A break also raises the framing error.
// - After a break the receiver idles until a stop bit arrives.
// - With break reset enabled, a break resets into programming mode.
// - Mode 1 frame: low start, eight data bits LSB first, high stop.
// - Modes 2,3 add a ninth data bit before the stop bit.
// - Data buffer write starts transmit; start bit starts enabled receive in modes 1-3, never in mode 0.
`include "uart_baud_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module uart_baud_frame (
    // Clock and reset
    input wire ref_clk_in,
    input wire rst_n_in,
    // Register port
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire [7:0] reg_bit_mask_in,
    output reg [7:0] reg_rdata_out,
    // Loose control bits
    input wire timer_baud_doubling_in,
    input wire frame_error_view_select_in,
    input wire break_reset_enable_in,
    input wire [7:0] timer_one_reload_value_in,
    // Serial lines
    input wire rxd_in,
    output reg txd_out,
    // Break reset request
    output reg isp_reset_out
);
// ----------------------------------------
// Reset release
// ----------------------------------------
reg [1:0] rst_sync_q;
wire rst_n;
always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
end
assign rst_n = rst_sync_q[1];
// ----------------------------------------
// Registers
// ----------------------------------------
reg [7:0] ctrl_q;
reg fe_q, brk_q;
reg [1:0] bgc_q;
reg [7:0] div_lo_q, div_hi_q;
reg [7:0] txbuf_q;
reg [7:0] rxbuf_q;
wire [1:0] mode = {ctrl_q[7], ctrl_q[6]};
wire wr_ctrl = reg_wr_in && (reg_addr_in == `ADDR_SERIAL_CTRL);
wire wr_stat = reg_wr_in && (reg_addr_in == `ADDR_STATUS);
wire [7:0] ctrl_wv = (ctrl_q & ~reg_bit_mask_in) | (reg_wdata_in & reg_bit_mask_in);
reg fe_set, brk_set, rx_done, rb8_d, tx_done;
always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
        ctrl_q <= `CTRL_RESET;
        fe_q <= 1'b0;
        brk_q <= 1'b0;
        bgc_q <= 2'b00;
        div_lo_q <= 8'h00;
        div_hi_q <= 8'h00;
        txbuf_q <= 8'h00;
    end else begin
        if (wr_ctrl) begin
            ctrl_q[6:0] <= ctrl_wv[6:0];
            if (!frame_error_view_select_in) ctrl_q[7] <= ctrl_wv[7];
        end
        if (rx_done) ctrl_q[0] <= 1'b1;
        if (rx_done) ctrl_q[2] <= rb8_d;
        if (tx_done) ctrl_q[1] <= 1'b1;
        if (fe_set || brk_set) fe_q <= 1'b1;
        else if (wr_ctrl && frame_error_view_select_in && !ctrl_wv[7]) fe_q <= 1'b0;
        else if (wr_stat && !reg_wdata_in[`STAT_FRAME_ERR]) fe_q <= 1'b0;
        if (brk_set) brk_q <= 1'b1;
        else if (wr_stat && !reg_wdata_in[`STAT_BREAK]) brk_q <= 1'b0;
        if (reg_wr_in && reg_addr_in == `ADDR_BAUD_CTRL) bgc_q <= reg_wdata_in[1:0];
        // Loaded unconditionally; changes while running are unpredictable
        if (reg_wr_in && reg_addr_in == `ADDR_DIV_LOW) div_lo_q <= reg_wdata_in;
        if (reg_wr_in && reg_addr_in == `ADDR_DIV_HIGH) div_hi_q <= reg_wdata_in;
        if (reg_wr_in && reg_addr_in == `ADDR_DATA_BUF) txbuf_q <= reg_wdata_in;
    end
end
// ----------------------------------------
// Read mux
// ----------------------------------------
always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) reg_rdata_out <= 8'h00;
    else begin
        case (reg_addr_in)
            `ADDR_SERIAL_CTRL: reg_rdata_out <= {frame_error_view_select_in ? fe_q : ctrl_q[7], ctrl_q[6:0]};
            `ADDR_DATA_BUF: reg_rdata_out <= rxbuf_q;
            `ADDR_STATUS: reg_rdata_out <= {6'h00, brk_q, fe_q};
            `ADDR_BAUD_CTRL: reg_rdata_out <= {6'h00, bgc_q};
            `ADDR_DIV_LOW: reg_rdata_out <= div_lo_q;
            `ADDR_DIV_HIGH: reg_rdata_out <= div_hi_q;
            default: reg_rdata_out <= 8'h00;
        endcase
    end
end
// ----------------------------------------
// Bit timing
// ----------------------------------------
wire [15:0] gen_div = {div_hi_q, div_lo_q} + `DIV_GEN_ADD;
wire [15:0] t1_len = {7'h00, `T1_BASE - {1'b0, timer_one_reload_value_in}};
wire [15:0] t1_slow = t1_len << `T1_MUL_SLOW;
wire [15:0] t1_fast = t1_len << `T1_MUL_FAST;
wire baud_run = !(mode[0] && bgc_q[`BGC_SOURCE] && !bgc_q[`BGC_ENABLE]);
reg [15:0] bit_len;
always @* begin
    case (mode)
        2'b00: bit_len = `DIV_FAST;
        2'b10: bit_len = timer_baud_doubling_in ? `DIV_FAST : `DIV_SLOW;
        default: begin
            if (bgc_q[`BGC_SOURCE]) bit_len = gen_div;
            else bit_len = timer_baud_doubling_in ? t1_fast : t1_slow;
        end
    endcase
end
// Transmit bit tick, free running
reg [15:0] cnt_q;
reg bit_tick;
always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
        cnt_q <= 16'h0000;
        bit_tick <= 1'b0;
    end else begin
        bit_tick <= 1'b0;
        if (!baud_run) cnt_q <= 16'h0000;
        else if (cnt_q >= bit_len - 16'h0001) begin
            cnt_q <= 16'h0000;
            bit_tick <= 1'b1;
        end else cnt_q <= cnt_q + 16'h0001;
    end
end
// ----------------------------------------
// Receive input synchroniser
// ----------------------------------------
reg [2:0] rx_sync_q;
reg rx_q;
always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
        rx_sync_q <= 3'b111;
        rx_q <= 1'b1;
    end else begin
        rx_sync_q <= {rx_sync_q[1:0], rxd_in};
        if (rx_sync_q[2] == rx_sync_q[1]) rx_q <= rx_sync_q[2];
    end
end
// ----------------------------------------
// Receiver
// ----------------------------------------
localparam RX_IDLE = 2'd0, RX_SHIFT = 2'd1, RX_BREAK = 2'd2;
reg [1:0] rx_st_q;
reg [3:0] rx_cnt_q, low_cnt_q;
reg [8:0] rx_sh_q;
reg [15:0] rx_ph_q;
wire [3:0] rx_bits = mode[1] ? 4'd10 : 4'd9;
// Receive sample tick, mid-bit from the start edge
wire rx_tick = (rx_st_q == RX_SHIFT) && baud_run && (rx_ph_q == 16'h0000);
always @* begin
    fe_set = 1'b0;
    brk_set = 1'b0;
    rx_done = 1'b0;
    rb8_d = 1'b0;
    if (rx_tick && rx_cnt_q == rx_bits) begin
        rb8_d = mode[1] ? rx_sh_q[8] : rx_q;
        if (!rx_q) fe_set = 1'b1;
        if (!rx_q && low_cnt_q >= `BREAK_BITS - 1) brk_set = 1'b1;
        else rx_done = 1'b1;
    end
end
always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
        rx_st_q <= RX_IDLE;
        rx_cnt_q <= 4'd0;
        low_cnt_q <= 4'd0;
        rx_sh_q <= 9'h000;
        rxbuf_q <= 8'h00;
        rx_ph_q <= 16'h0000;
    end else begin
        case (rx_st_q)
            RX_IDLE: begin
                low_cnt_q <= 4'd0;
                if (ctrl_q[4] && mode != 2'b00 && !rx_q) begin
                    rx_st_q <= RX_SHIFT;
                    rx_cnt_q <= 4'd0;
                    rx_ph_q <= {1'b0, bit_len[15:1]};
                end
            end
            RX_SHIFT: begin
                if (rx_tick) begin
                    rx_ph_q <= bit_len - 16'h0001;
                    rx_cnt_q <= rx_cnt_q + 4'd1;
                    low_cnt_q <= rx_q ? 4'd0 : (low_cnt_q == 4'hf ? 4'hf : low_cnt_q + 4'd1);
                    // A high start sample was a glitch
                    if (rx_cnt_q == 4'd0 && rx_q) rx_st_q <= RX_IDLE;
                    if (rx_cnt_q != 4'd0 && rx_cnt_q != rx_bits) begin
                        if (mode[1]) rx_sh_q <= {rx_q, rx_sh_q[8:1]};
                        else rx_sh_q <= {1'b0, rx_q, rx_sh_q[7:1]};
                    end
                    if (rx_cnt_q == rx_bits) begin
                        rx_cnt_q <= 4'd0;
                        if (brk_set) rx_st_q <= RX_BREAK;
                        else begin
                            rxbuf_q <= rx_sh_q[7:0];
                            // A low stop keeps sampling so a break across frames is counted
                            if (rx_q) rx_st_q <= RX_IDLE;
                        end
                    end
                end else if (rx_ph_q != 16'h0000) rx_ph_q <= rx_ph_q - 16'h0001;
            end
            RX_BREAK: begin
                if (rx_q) rx_st_q <= RX_IDLE;
            end
            default: rx_st_q <= RX_IDLE;
        endcase
    end
end
// ----------------------------------------
// Transmitter and break reset
// ----------------------------------------
reg [10:0] tx_sh_q;
reg [3:0] tx_cnt_q;
reg tx_busy_q;
always @* tx_done = tx_busy_q && bit_tick && tx_cnt_q == 4'd0;
always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
        tx_sh_q <= 11'h7FF;
        tx_cnt_q <= 4'd0;
        tx_busy_q <= 1'b0;
        txd_out <= 1'b1;
        isp_reset_out <= 1'b0;
    end else begin
        isp_reset_out <= brk_set && break_reset_enable_in;
        if (reg_wr_in && reg_addr_in == `ADDR_DATA_BUF) begin
            tx_busy_q <= 1'b1;
            tx_cnt_q <= mode[1] ? 4'd11 : 4'd10;
            tx_sh_q <= mode[1] ? {1'b1, ctrl_q[3], reg_wdata_in, 1'b0} : {2'b11, reg_wdata_in, 1'b0};
        end else if (tx_busy_q && bit_tick) begin
            if (tx_cnt_q == 4'd0) tx_busy_q <= 1'b0;
            else begin
                txd_out <= tx_sh_q[0];
                tx_sh_q <= {1'b1, tx_sh_q[10:1]};
                tx_cnt_q <= tx_cnt_q - 4'd1;
            end
        end
    end
end
endmodule
`default_nettype wire

// ==== shared/uart_baud_consts.vh ====
`ifndef UART_BAUD_CONSTS_VH
`define UART_BAUD_CONSTS_VH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_SERIAL_CTRL 8'h98
`define ADDR_DATA_BUF 8'h99
`define ADDR_STATUS 8'hBA
`define ADDR_BAUD_CTRL 8'hBD
`define ADDR_DIV_LOW 8'hBE
`define ADDR_DIV_HIGH 8'hBF
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define BGC_ENABLE 0
`define BGC_SOURCE 1
`define CTRL_RESET 8'h00
`define STAT_FRAME_ERR 0
`define STAT_BREAK 1
// ----------------------------------------
// Divisors and counts
// ----------------------------------------
`define DIV_SLOW 16'h0020
`define DIV_FAST 16'h0010
`define DIV_GEN_ADD 16'h0010
`define T1_BASE 9'h100
`define T1_MUL_SLOW 6
`define T1_MUL_FAST 5
`define OVS_COUNT 16
`define BREAK_BITS 11
`endif

// ==== tb/uart_baud_frame_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module uart_baud_frame_sva (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_bit_mask_in,
    input wire logic [7:0] reg_rdata_out,
    // Levels and lines
    input wire logic timer_baud_doubling_in,
    input wire logic frame_error_view_select_in,
    input wire logic break_reset_enable_in,
    input wire logic [7:0] timer_one_reload_value_in,
    input wire logic rxd_in,
    input wire logic txd_out,
    input wire logic isp_reset_out
);
    // --
    // Checks
    // --
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_reset_idle: assert property ($rose(rst_n_in) |-> txd_out && !isp_reset_out)
        else $error("outputs busy after reset");
    a_isp_single: assert property (isp_reset_out |=> !isp_reset_out)
        else $error("break reset pulse too long");
    a_isp_enabled: assert property (isp_reset_out |-> $past(break_reset_enable_in))
        else $error("break reset while disabled");
    a_isp_rx_low: assert property (isp_reset_out |-> $past(rxd_in, 6) == 1'b0)
        else $error("break reset on a high line");
    a_bgc_readback: assert property ((reg_wr_in && reg_addr_in == 8'hbd) ##1
        (reg_addr_in == 8'hbd && !reg_wr_in) |=> reg_rdata_out[1:0] == $past(reg_wdata_in[1:0], 2))
        else $error("generator control lost");
    a_ctrl_readback: assert property ((reg_wr_in && reg_addr_in == 8'h98 && reg_bit_mask_in == 8'hff
        && !frame_error_view_select_in) ##1 (reg_addr_in == 8'h98 && !reg_wr_in && !frame_error_view_select_in)
        |=> reg_rdata_out[7:3] == $past(reg_wdata_in[7:3], 2)) else $error("control bits lost");
    a_fe_clear: assert property ((reg_wr_in && reg_addr_in == 8'h98 && reg_bit_mask_in[7]
        && !reg_wdata_in[7] && frame_error_view_select_in) ##1 (reg_addr_in == 8'h98
        && frame_error_view_select_in) |=> !reg_rdata_out[7]) else $error("framing flag not cleared");
    a_tx_start: assert property ((reg_wr_in && reg_addr_in == 8'h99) |-> ##[1:300] !txd_out)
        else $error("no start bit after data write");
    c_break_reset: cover property (isp_reset_out);
    c_tx_start: cover property ($fell(txd_out));
    c_fe_view: cover property (frame_error_view_select_in && reg_rdata_out[7]);
endmodule
bind uart_baud_frame uart_baud_frame_sva i_uart_baud_frame_sva (.ref_clk_in, .rst_n_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_bit_mask_in, .reg_rdata_out, .timer_baud_doubling_in,
    .frame_error_view_select_in, .break_reset_enable_in, .timer_one_reload_value_in, .rxd_in, .txd_out,
    .isp_reset_out);
`default_nettype wire

// ==== tb/serial_station.sv ====
`timescale 1ns/100ps
`default_nettype none
module serial_station (
    // Clock
    input wire logic ref_clk_in,
    // Serial lines
    input wire logic txd_in,
    output logic rxd_out,
    input wire logic [15:0] bit_cycles_in,
    // Frame seen on the line
    output logic got_out,
    output logic [9:0] got_bits_out,
    output logic [15:0] got_width_out
);
    // --
    // Send lsb first, measure and sample
    // --
    initial rxd_out = 1'b1;
    initial got_out = 1'b0;
    task automatic send(input logic [31:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            rxd_out <= bits[i];
            repeat (bit_cycles_in) @(posedge ref_clk_in);
        end
        rxd_out <= 1'b1;
    endtask
    always begin
        @(posedge ref_clk_in iff txd_in === 1'b0);
        got_width_out = 16'h0000;
        do begin
            got_width_out++;
            @(posedge ref_clk_in);
        end while (txd_in === 1'b0);
        repeat (got_width_out / 2) @(posedge ref_clk_in);
        for (int i = 0; i < 10; i++) begin
            got_bits_out[i] = txd_in;
            repeat (got_width_out) @(posedge ref_clk_in);
        end
        got_out <= 1'b1;
        @(posedge ref_clk_in);
        got_out <= 1'b0;
    end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, dbl = 1'b0, view = 1'b0, brk = 1'b0;
    logic rxd, txd, in_system_programming, got;
    logic [7:0] addr = 8'h00, wd = 8'h00, msk = 8'hff, rl = 8'hff, rd, d, r;
    logic [15:0] bitc = 16'h0020, per, dv, gw;
    logic [9:0] gbits;
    logic [25:0] exp_q[$];
    logic [1:0] md[6] = '{2'b10, 2'b10, 2'b01, 2'b11, 2'b01, 2'b11};
    int err_count = 0, checked = 0, isp_seen = 0;
    // --
    // Clock, design and far side
    // --
    initial forever #10 clk = ~clk;
    uart_baud_frame i_uart_baud_frame (.ref_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_bit_mask_in(msk), .reg_rdata_out(rd),
        .timer_baud_doubling_in(dbl), .frame_error_view_select_in(view), .break_reset_enable_in(brk),
        .timer_one_reload_value_in(rl), .rxd_in(rxd), .txd_out(txd), .isp_reset_out(in_system_programming));
    serial_station i_serial_station (.ref_clk_in(clk), .txd_in(txd), .rxd_out(rxd), .bit_cycles_in(bitc),
        .got_out(got), .got_bits_out(gbits), .got_width_out(gw));
    task automatic check_frame(input string n, input logic [25:0] e, input logic [25:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic check_reg(input string n, input logic [7:0] e, input logic [7:0] g);
        check_frame(n, {18'h0_0000, e}, {18'h0_0000, g});
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m);
        addr <= a;
        wd <= v;
        msk <= m;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        addr <= a;
        repeat (2) @(posedge clk);
        check_reg($sformatf("reg %h", a), e & m, rd & m);
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk) begin
        if (in_system_programming === 1'b1) isp_seen++;
        if (got === 1'b1) check_frame("frame", exp_q.pop_front(), {gw, gbits});
    end
    initial begin
        repeat (80000) @(posedge clk);
        err_count++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'h97df));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int s = 0; s < 6; s++) begin
            dv = 16'($urandom_range(47));
            r = 8'hfc | 8'($urandom_range(3));
            per = 16'(s < 2 ? (s[0] ? 16 : 32) : s < 4 ? (256 - r) * (s[0] ? 32 : 64) : dv + 16);
            dbl <= s[0];
            rl <= r;
            wr_reg(8'hbd, 8'h00, 8'hff);
            wr_reg(8'hbe, dv[7:0], 8'hff);
            wr_reg(8'hbf, dv[15:8], 8'hff);
            wr_reg(8'hbd, {6'h00, s > 3, 1'b1}, 8'hff);
            wr_reg(8'h98, {md[s], 6'h10}, 8'hff);
            rd_reg(8'hbd, {6'h00, s > 3, 1'b1}, 8'h03);
            rd_reg(8'h98, {md[s], 6'h10}, 8'hf8);
            d = 8'($urandom) | 8'h01;
            bitc <= per;
            exp_q.push_back({per, md[s] == 2'b01 ? 2'b11 : 2'b10, d});
            wr_reg(8'h99, d, 8'hff);
            repeat (14 * per) @(posedge clk);
        end
        wr_reg(8'h98, 8'h50, 8'hff);
        wr_reg(8'hba, 8'h00, 8'hff);
        i_serial_station.send({1'b0, d, 1'b0}, 10);
        repeat (2 * per) @(posedge clk);
        rd_reg(8'hba, 8'h01, 8'h01);
        i_serial_station.send({1'b1, ~d, 1'b0}, 10);
        repeat (2 * per) @(posedge clk);
        rd_reg(8'hba, 8'h01, 8'h01);
        rd_reg(8'h99, ~d, 8'hff);
        view <= 1'b1;
        rd_reg(8'h98, 8'h80, 8'h80);
        wr_reg(8'h98, 8'h00, 8'h80);
        rd_reg(8'hba, 8'h00, 8'h01);
        view <= 1'b0;
        rd_reg(8'h98, 8'h50, 8'hf8);
        i_serial_station.send(32'h0000_0000, 22);
        repeat (2 * per) @(posedge clk);
        rd_reg(8'hba, 8'h03, 8'h03);
        wr_reg(8'hba, 8'h00, 8'hff);
        i_serial_station.send({1'b1, d, 1'b0}, 10);
        repeat (2 * per) @(posedge clk);
        rd_reg(8'h99, d, 8'hff);
        brk <= 1'b1;
        i_serial_station.send(32'h0000_0000, 22);
        repeat (2 * per) @(posedge clk);
        check_reg("isp pulses", 8'h01, 8'(isp_seen));
        report_and_stop();
    end
endmodule
`default_nettype wire
